// ---- rtl/sgs_pkg.sv ----
// Package for the gain switchover selector: register map, field layout,
// reset values, timing constants, condition codes and the state record.
// Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package sgs_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int DELAY_UNIT_NS = 1000000;
    localparam int TICK_CYCLES_DEF = DELAY_UNIT_NS / CLK_PERIOD_NS;

    localparam logic [7:0] COND_OFS = 8'h00;
    localparam logic [7:0] LEVEL_OFS = 8'h04;
    localparam logic [7:0] HYST_OFS = 8'h08;
    localparam logic [7:0] DELAY_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    localparam logic [3:0] COND_RST = 4'h0;
    localparam logic [3:0] COND_MAX = 4'ha;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam logic [15:0] HYST_RST = 16'h0000;
    localparam logic [15:0] DELAY_RST = 16'h0000;

    localparam int STAT_GAIN2_BIT = 0;
    localparam int STAT_BLEND_LSB = 8;
    localparam int STAT_COND_LSB = 16;

    localparam logic [7:0] BLEND_MAX = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        COND_FIXED = 4'h0,
        COND_INPUT = 4'h1,
        COND_TORQUE = 4'h2,
        COND_SPEED = 4'h3,
        COND_RATE = 4'h4,
        COND_BLEND = 4'h5,
        COND_POSDEV = 4'h6
    } sgs_cond_e;

    typedef enum logic [1:0] {
        MODE_POSITION = 2'h0,
        MODE_SPEED = 2'h1,
        MODE_TORQUE = 2'h2,
        MODE_CLOSED = 2'h3
    } sgs_mode_e;

    typedef struct packed {
        logic [3:0] cond;
        logic [15:0] level;
        logic [15:0] hyst;
        logic [15:0] delay;
        logic [23:0] tick_cnt;
        logic [15:0] dly_cnt;
        logic gain2;
        logic [7:0] blend;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sgs_state_s;

endpackage

// ---- rtl/sgs_selector.sv ----
// Gain switchover selector with its AXI4-Lite configuration slave.
// Assumes all drive inputs are synchronous to sys_clk_in and that the
// control loops read gain2_sel_out and blend_out every cycle.
`timescale 1ns/100ps
`default_nettype none

module sgs_selector
    import sgs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input wire logic sys_clk_in, // System clock, 20 MHz.
    input wire logic nrst_in, // Asynchronous reset, active low.
    input wire logic awvalid_in, // Write address valid.
    output logic awready_out, // Write address ready.
    input wire logic [7:0] awaddr_in, // Write byte address.
    input wire logic wvalid_in, // Write data valid.
    output logic wready_out, // Write data ready.
    input wire logic [31:0] wdata_in, // Write data.
    input wire logic [3:0] wstrb_in, // Write byte strobes.
    output logic bvalid_out, // Write response valid.
    input wire logic bready_in, // Write response ready.
    output logic [1:0] bresp_out, // Write response code.
    input wire logic arvalid_in, // Read address valid.
    output logic arready_out, // Read address ready.
    input wire logic [7:0] araddr_in, // Read byte address.
    output logic rvalid_out, // Read data valid.
    input wire logic rready_in, // Read data ready.
    output logic [31:0] rdata_out, // Read data.
    output logic [1:0] rresp_out, // Read response code.
    input wire logic [31:0] torque_ref_in, // Torque reference, percent, signed.
    input wire logic [31:0] speed_ref_in, // Speed reference, RPM, signed.
    input wire logic [31:0] speed_rate_in, // Speed reference change rate, 10 RPM/s, signed.
    input wire logic [31:0] pos_dev_in, // Position deviation, encoder units, signed.
    input wire logic [1:0] ctrl_mode_in, // Active control mode.
    input wire logic gain_sel_in, // Gain select from digital_input_terminal.
    input wire logic gain_sel_assigned_in, // A terminal carries the gain select function.
    output logic gain2_sel_out, // High while the second gain set is in use.
    output logic [7:0] blend_out // Blend factor, 0 first gain, max second gain.
);

    sgs_state_s s_reg;
    sgs_state_s s_next;
    logic [31:0] mag;
    logic [31:0] hi_thr;
    logic [31:0] lo_thr;
    logic force1;
    logic hyst_code;
    logic tick;

    function automatic logic [31:0] abs32(input logic [31:0] v);
        abs32 = v[31] ? (~v + 32'h0000_0001) : v;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    always_comb
    begin
        case (s_reg.cond)
            COND_TORQUE: mag = abs32(torque_ref_in);
            COND_SPEED, COND_BLEND: mag = abs32(speed_ref_in);
            COND_RATE: mag = abs32(speed_rate_in);
            COND_POSDEV: mag = abs32(pos_dev_in);
            default: mag = 32'h0000_0000;
        endcase
    end

    // The lower threshold saturates at zero when hysteresis exceeds level.
    assign hi_thr = {16'h0000, s_reg.level} + {16'h0000, s_reg.hyst};
    assign lo_thr = (s_reg.level > s_reg.hyst) ? {16'h0000, s_reg.level - s_reg.hyst} : 32'h0000_0000;
    assign hyst_code = (s_reg.cond == COND_TORQUE) || (s_reg.cond == COND_SPEED)
                       || (s_reg.cond == COND_RATE) || (s_reg.cond == COND_POSDEV);
    assign force1 = ((s_reg.cond == COND_SPEED || s_reg.cond == COND_RATE)
                     && ctrl_mode_in == MODE_SPEED)
                    || (s_reg.cond == COND_POSDEV && ctrl_mode_in != MODE_POSITION
                        && ctrl_mode_in != MODE_CLOSED)
                    || (s_reg.cond == COND_FIXED) || (s_reg.cond > COND_POSDEV);
    assign tick = (s_reg.tick_cnt == 24'(TICK_CYCLES - 1));

    always_comb
    begin
        s_next = s_reg;
        s_next.tick_cnt = tick ? 24'h000000 : s_reg.tick_cnt + 24'h000001;

        // Write channel: address and data are taken in either order.
        if (awvalid_in && !s_reg.aw_have)
        begin
            s_next.aw_have = 1'b1;
            s_next.awaddr = awaddr_in;
        end
        if (wvalid_in && !s_reg.w_have)
        begin
            s_next.w_have = 1'b1;
            s_next.wdata = wdata_in;
            s_next.wstrb = wstrb_in;
        end
        if (s_reg.bvalid && bready_in)
        begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid)
        begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            case (s_reg.awaddr)
                COND_OFS:
                begin
                    if (s_reg.wstrb[0] && s_reg.wdata[7:0] <= {4'h0, COND_MAX})
                    begin
                        s_next.cond = s_reg.wdata[3:0];
                    end
                end
                LEVEL_OFS: s_next.level = merge16(s_reg.level, s_reg.wdata, s_reg.wstrb);
                HYST_OFS: s_next.hyst = merge16(s_reg.hyst, s_reg.wdata, s_reg.wstrb);
                DELAY_OFS: s_next.delay = merge16(s_reg.delay, s_reg.wdata, s_reg.wstrb);
                STATUS_OFS: s_next.bresp = RESP_OKAY;
                default: s_next.bresp = RESP_SLVERR;
            endcase
        end

        // Read channel: one read in flight, answered the cycle after it is taken.
        if (s_reg.rvalid && rready_in)
        begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid_in && !s_reg.rvalid)
        begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            s_next.rdata = 32'h0000_0000;
            case (araddr_in)
                COND_OFS: s_next.rdata[3:0] = s_reg.cond;
                LEVEL_OFS: s_next.rdata[15:0] = s_reg.level;
                HYST_OFS: s_next.rdata[15:0] = s_reg.hyst;
                DELAY_OFS: s_next.rdata[15:0] = s_reg.delay;
                STATUS_OFS:
                begin
                    s_next.rdata[STAT_GAIN2_BIT] = s_reg.gain2;
                    s_next.rdata[STAT_BLEND_LSB +: 8] = s_reg.blend;
                    s_next.rdata[STAT_COND_LSB +: 4] = s_reg.cond;
                end
                default: s_next.rresp = RESP_SLVERR;
            endcase
        end

        // Gain selection.
        if (force1)
        begin
            s_next.gain2 = 1'b0;
            s_next.dly_cnt = 16'h0000;
        end
        else if (s_reg.cond == COND_INPUT)
        begin
            s_next.gain2 = gain_sel_assigned_in && gain_sel_in;
            s_next.dly_cnt = 16'h0000;
        end
        else if (s_reg.cond == COND_BLEND)
        begin
            s_next.dly_cnt = 16'h0000;
            if (mag > hi_thr)
            begin
                s_next.blend = BLEND_MAX;
                s_next.gain2 = 1'b1;
            end
            else if (mag <= lo_thr)
            begin
                s_next.blend = 8'h00;
                s_next.gain2 = 1'b0;
            end
            else if (tick && !s_reg.gain2)
            begin
                s_next.blend = s_reg.blend + 8'h01;
                s_next.gain2 = (s_reg.blend == BLEND_MAX - 8'h01);
            end
            else if (tick && s_reg.gain2)
            begin
                s_next.blend = s_reg.blend - 8'h01;
                s_next.gain2 = (s_reg.blend != 8'h01);
            end
        end
        else if (hyst_code)
        begin
            if (!s_reg.gain2)
            begin
                s_next.dly_cnt = 16'h0000;
                s_next.gain2 = (mag > hi_thr);
            end
            else if (mag > lo_thr)
            begin
                s_next.dly_cnt = 16'h0000;
            end
            else if (s_reg.dly_cnt >= s_reg.delay)
            begin
                s_next.gain2 = 1'b0;
                s_next.dly_cnt = 16'h0000;
            end
            else if (tick)
            begin
                s_next.dly_cnt = s_reg.dly_cnt + 16'h0001;
            end
        end
        if (s_reg.cond != COND_BLEND)
        begin
            s_next.blend = s_next.gain2 ? BLEND_MAX : 8'h00;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_reg <= '0;
            s_reg.cond <= COND_RST;
            s_reg.level <= LEVEL_RST;
            s_reg.hyst <= HYST_RST;
            s_reg.delay <= DELAY_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign awready_out = !s_reg.aw_have;
    assign wready_out = !s_reg.w_have;
    assign bvalid_out = s_reg.bvalid;
    assign bresp_out = s_reg.bresp;
    assign arready_out = !s_reg.rvalid;
    assign rvalid_out = s_reg.rvalid;
    assign rdata_out = s_reg.rdata;
    assign rresp_out = s_reg.rresp;
    assign gain2_sel_out = s_reg.gain2;
    assign blend_out = s_reg.blend;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);

    fixed_first_a: assert property (
        (s_reg.cond == COND_FIXED) [*2] |-> !gain2_sel_out && blend_out == 8'h00)
        else $error("Code zero left the first gain.");
    input_select_a: assert property (
        s_reg.cond == COND_INPUT && $past(s_reg.cond) == COND_INPUT
        |-> gain2_sel_out == $past(gain_sel_in && gain_sel_assigned_in))
        else $error("Input mode gain does not follow the select input.");
    level_rise_a: assert property (
        hyst_code && !force1 && !s_reg.gain2 && mag > hi_thr |=> gain2_sel_out && blend_out == BLEND_MAX)
        else $error("Second gain not taken above upper threshold.");
    hold_above_a: assert property (
        hyst_code && !force1 && s_reg.gain2 && mag > lo_thr |=> gain2_sel_out && s_reg.dly_cnt == 16'h0000)
        else $error("Second gain left or delay kept while above lower threshold.");
    delay_wait_a: assert property (
        hyst_code && !force1 && s_reg.gain2 && mag <= lo_thr && s_reg.dly_cnt < s_reg.delay |=> gain2_sel_out)
        else $error("Return to first gain before the delay expired.");
    delay_return_a: assert property (
        hyst_code && !force1 && s_reg.gain2 && mag <= lo_thr && s_reg.dly_cnt >= s_reg.delay |=> !gain2_sel_out)
        else $error("No return to first gain after the delay.");
    mode_force_a: assert property (
        force1 |=> !gain2_sel_out)
        else $error("Forced first gain not applied.");
    blend_full_a: assert property (
        s_reg.cond == COND_BLEND && mag > hi_thr |=> blend_out == BLEND_MAX && gain2_sel_out)
        else $error("Blend not full above upper threshold.");
    blend_zero_a: assert property (
        s_reg.cond == COND_BLEND && mag <= lo_thr |=> blend_out == 8'h00 && !gain2_sel_out)
        else $error("Blend not cleared at lower threshold.");
    blend_ramp_a: assert property (
        s_reg.cond == COND_BLEND && mag > lo_thr && mag <= hi_thr && tick
        |=> blend_out == ($past(s_reg.gain2) ? $past(s_reg.blend) - 8'h01 : $past(s_reg.blend) + 8'h01))
        else $error("Blend did not step toward the target.");
    cond_range_a: assert property (
        s_reg.cond <= COND_MAX)
        else $error("Condition code out of range.");
    no_terminal_a: assert property (
        s_reg.cond == COND_INPUT && !gain_sel_assigned_in |=> !gain2_sel_out)
        else $error("Input mode without a terminal left the first gain.");
    rate_force_a: assert property (
        s_reg.cond == COND_RATE && ctrl_mode_in == MODE_SPEED |=> !gain2_sel_out && blend_out == 8'h00)
        else $error("Change rate condition left the first gain in speed control.");
    posdev_force_a: assert property (
        s_reg.cond == COND_POSDEV && (ctrl_mode_in == MODE_SPEED || ctrl_mode_in == MODE_TORQUE)
        |=> !gain2_sel_out)
        else $error("Deviation condition left the first gain outside position control.");
    speed_force_a: assert property (
        s_reg.cond == COND_SPEED && ctrl_mode_in == MODE_SPEED |=> !gain2_sel_out)
        else $error("Speed condition acted in speed control mode.");
    delay_count_a: assert property (
        hyst_code && !force1 && s_reg.gain2 && mag <= lo_thr && s_reg.dly_cnt < s_reg.delay && tick
        |=> s_reg.dly_cnt == $past(s_reg.dly_cnt) + 16'h0001)
        else $error("Delay count did not advance on a tick.");
    blend_follow_a: assert property (
        s_reg.cond != COND_BLEND && $past(s_reg.cond) != COND_BLEND
        |-> blend_out == (gain2_sel_out ? BLEND_MAX : 8'h00))
        else $error("Blend factor disagrees with the selected gain set.");
    cond_write_a: assert property (
        s_reg.aw_have && s_reg.w_have && !s_reg.bvalid && s_reg.awaddr == COND_OFS
        && s_reg.wdata[7:0] > {4'h0, COND_MAX} |=> s_reg.cond == $past(s_reg.cond))
        else $error("Out-of-range condition code was accepted.");

    // The bus channels hold each answer until the master accepts it.
    bresp_hold_a: assert property (
        bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
        else $error("Write response dropped before it was accepted.");
    rdata_hold_a: assert property (
        rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out) && $stable(rresp_out))
        else $error("Read data changed before it was accepted.");
    wr_answer_a: assert property (
        s_reg.aw_have && s_reg.w_have && !s_reg.bvalid |=> bvalid_out)
        else $error("Write not answered after address and data were taken.");
    rd_answer_a: assert property (
        arvalid_in && arready_out |=> rvalid_out)
        else $error("Read not answered after its address was taken.");

    switch_up_c: cover property (hyst_code && !s_reg.gain2 ##1 s_reg.gain2);
    switch_back_c: cover property (hyst_code && s_reg.gain2 && s_reg.dly_cnt != 16'h0000 ##1 !s_reg.gain2);
    blend_mid_c: cover property (s_reg.cond == COND_BLEND && s_reg.blend == 8'h80);
    blend_up_c: cover property (s_reg.cond == COND_BLEND && !s_reg.gain2 && s_reg.blend == 8'h01);
    input_high_c: cover property (s_reg.cond == COND_INPUT && s_reg.gain2);

endmodule

`default_nettype wire

// ---- sim/sgs_drive_model.sv ----
// Far-side model: the drive's reference and feedback sources and the input terminals.
// Assumes the bench sets the wanted values; they reach the selector one clock later.
`timescale 1ns/100ps
`default_nettype none

module sgs_drive_model
(
    input wire logic clk_in, // System clock.
    input wire logic nrst_in, // Reset, active low.
    input wire logic [31:0] mag_in, // Signed value for every monitored quantity.
    input wire logic [1:0] mode_in, // Control mode to present.
    input wire logic term_in, // Terminal level.
    input wire logic term_map_in, // Terminal carries the gain select function.
    output logic [31:0] quant_out, // Value presented on all quantities.
    output logic [1:0] mode_out, // Control mode.
    output logic term_out, // Gain select level.
    output logic term_map_out // Gain select assignment.
);
    // One value feeds all quantities, so each condition code sees the same stimulus.
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            quant_out <= 32'h00000000;
            mode_out <= 2'h0;
            term_out <= 1'b0;
            term_map_out <= 1'b0;
        end
        else
        begin
            quant_out <= mag_in;
            mode_out <= mode_in;
            term_out <= term_in;
            term_map_out <= term_map_in;
        end
    end
endmodule

`default_nettype wire

// ---- sim/sgs_selector_bench.sv ----
// Self-checking bench for the gain switchover selector.
// Assumes a 20 MHz clock and a 4-cycle delay tick to keep hold delays short.
`timescale 1ns/100ps
`default_nettype none

module sgs_selector_bench
    import sgs_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, mag = 32'h0;
    logic [1:0] mode = 2'h0;
    logic term = 1'b0, dimap = 1'b0;
    logic awr, wr_rdy, bv, arr, rv, g2, qdi, qmap;
    logic [1:0] br, rr, qmode;
    logic [31:0] rd_d, q;
    logic [7:0] bl;
    int fails = 0;
    int comparisons = 0;
    logic [3:0] tc [5] = '{4'h3, 4'h4, 4'h6, 4'h6, 4'h6};
    logic [1:0] tm [5] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h3};
    logic [3:0] codes [4] = '{4'h2, 4'h3, 4'h4, 4'h6};

    always #25 clk = ~clk;

    sgs_drive_model partner (.clk_in(clk), .nrst_in(nrst), .mag_in(mag), .mode_in(mode), .term_in(term),
        .term_map_in(dimap), .quant_out(q), .mode_out(qmode), .term_out(qdi), .term_map_out(qmap));

    sgs_selector #(.TICK_CYCLES(4)) dut (.sys_clk_in(clk), .nrst_in(nrst),
        .awvalid_in(awv), .awready_out(awr), .awaddr_in(awa), .wvalid_in(wv), .wready_out(wr_rdy),
        .wdata_in(wd), .wstrb_in(4'hf), .bvalid_out(bv), .bready_in(brdy), .bresp_out(br),
        .arvalid_in(arv), .arready_out(arr), .araddr_in(ara), .rvalid_out(rv), .rready_in(rrdy),
        .rdata_out(rd_d), .rresp_out(rr), .torque_ref_in(q), .speed_ref_in(q), .speed_rate_in(q),
        .pos_dev_in(q), .ctrl_mode_in(qmode), .gain_sel_in(qdi), .gain_sel_assigned_in(qmap),
        .gain2_sel_out(g2), .blend_out(bl));

    task automatic report_and_stop;
        begin
            $display("comparisons=%0d fails=%0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        begin
            comparisons++;
            if (g !== e)
            begin
                fails++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        begin
            @(posedge clk);
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            brdy <= 1'b1;
            do
            begin
                @(posedge clk);
                if (awr)
                    awv <= 1'b0;
                if (wr_rdy)
                    wv <= 1'b0;
            end
            while (bv !== 1'b1);
            brdy <= 1'b0;
            chk({30'h0, br}, {30'h0, er});
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        begin
            @(posedge clk);
            ara <= a;
            arv <= 1'b1;
            rrdy <= 1'b1;
            do
            begin
                @(posedge clk);
                if (arr)
                    arv <= 1'b0;
            end
            while (rv !== 1'b1);
            rrdy <= 1'b0;
            chk(rd_d, ed);
            chk({30'h0, rr}, {30'h0, er});
        end
    endtask

    task automatic put(input logic [31:0] m, input logic [1:0] md, input logic d, input logic dm);
        begin
            @(posedge clk);
            mag <= m;
            mode <= md;
            term <= d;
            dimap <= dm;
        end
    endtask

    // The first two edges let a new value pass the partner and the selector.
    task automatic hold_g(input logic e, input int n);
        begin
            repeat (2) @(posedge clk);
            repeat (n)
            begin
                @(posedge clk);
                chk({31'h0, g2}, {31'h0, e});
            end
        end
    endtask

    task automatic wait_o(input logic [8:0] m, input logic [8:0] v, input logic eq, input int n);
        int i;
        begin
            i = 0;
            while (((({g2, bl} & m) === v) != eq) && i < n)
            begin
                @(posedge clk);
                i++;
            end
            if (eq)
                chk({23'h0, {g2, bl} & m}, {23'h0, v});
            else
                chk({31'h0, ({g2, bl} & m) === v}, 32'h0);
        end
    endtask

    initial
    begin
        #(50 * 20000);
        fails++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a <= 16; a += 4)
            rd(8'(a), 32'h0, RESP_OKAY);
        wr(COND_OFS, 32'hb, RESP_OKAY);
        rd(COND_OFS, 32'h0, RESP_OKAY);
        wr(COND_OFS, 32'ha, RESP_OKAY);
        rd(COND_OFS, 32'ha, RESP_OKAY);
        wr(8'h20, 32'h1, RESP_SLVERR);
        rd(8'h20, 32'h0, RESP_SLVERR);
        wr(LEVEL_OFS, 32'hffff000a, RESP_OKAY);
        rd(LEVEL_OFS, 32'h0000000a, RESP_OKAY);
        wr(HYST_OFS, 32'h2, RESP_OKAY);
        wr(DELAY_OFS, 32'h3, RESP_OKAY);
        put(32'h3e8, 2'h0, 1'b1, 1'b1);
        hold_g(1'b0, 4);
        wr(COND_OFS, 32'h0, RESP_OKAY);
        hold_g(1'b0, 4);
        wr(COND_OFS, 32'h1, RESP_OKAY);
        wait_o(9'h100, 9'h100, 1'b1, 10);
        put(32'h0, 2'h0, 1'b0, 1'b1);
        wait_o(9'h100, 9'h000, 1'b1, 10);
        put(32'h0, 2'h0, 1'b1, 1'b0);
        hold_g(1'b0, 4);
        foreach (codes[k])
        begin
            wr(COND_OFS, {28'h0, codes[k]}, RESP_OKAY);
            put(32'd12, 2'h0, 1'b0, 1'b0);
            hold_g(1'b0, 4);
            put(-32'sd13, 2'h0, 1'b0, 1'b0);
            wait_o(9'h100, 9'h100, 1'b1, 10);
            rd(STATUS_OFS, (32'(codes[k]) << STAT_COND_LSB) | (32'(BLEND_MAX) << STAT_BLEND_LSB) | 32'h1,
                RESP_OKAY);
            put(32'd8, 2'h0, 1'b0, 1'b0);
            hold_g(1'b1, 4);
            put(32'd11, 2'h0, 1'b0, 1'b0);
            hold_g(1'b1, 4);
            put(-32'sd8, 2'h0, 1'b0, 1'b0);
            hold_g(1'b1, 8);
            wait_o(9'h100, 9'h000, 1'b1, 40);
        end
        foreach (tc[k])
        begin
            wr(COND_OFS, {28'h0, tc[k]}, RESP_OKAY);
            put(32'd100, tm[k], 1'b0, 1'b0);
            if (k == 4)
                wait_o(9'h100, 9'h100, 1'b1, 10);
            else
                hold_g(1'b0, 4);
        end
        put(32'd100, 2'h1, 1'b0, 1'b0);
        wait_o(9'h100, 9'h000, 1'b1, 10);
        wr(LEVEL_OFS, 32'd20, RESP_OKAY);
        wr(HYST_OFS, 32'd5, RESP_OKAY);
        put(32'd0, 2'h3, 1'b0, 1'b0);
        wr(COND_OFS, 32'h5, RESP_OKAY);
        put(32'd20, 2'h3, 1'b0, 1'b0);
        wait_o(9'h1ff, 9'h001, 1'b1, 20);
        put(-32'sd30, 2'h3, 1'b0, 1'b0);
        wait_o(9'h1ff, 9'h1ff, 1'b1, 10);
        put(32'd20, 2'h3, 1'b0, 1'b0);
        wait_o(9'h1ff, 9'h1fe, 1'b1, 20);
        put(32'd15, 2'h3, 1'b0, 1'b0);
        wait_o(9'h1ff, 9'h000, 1'b1, 10);
        report_and_stop();
    end
endmodule

`default_nettype wire
